// ==== hdl/otc_pkg.sv ====
// Package of constants for the output terminal conditioning block
`default_nettype none
package otc_pkg;
  // ==========================================================
  // Register offsets (byte addresses, one word each)
  // ==========================================================
  localparam logic [7:0] OTC_SEL_OFS     = 8'h00; // Source selects
  localparam logic [7:0] OTC_PMAX_OFS    = 8'h04; // Max pulse freq, 0.01 kHz units
  localparam logic [7:0] OTC_AO1_OFS     = 8'h08; // Analog one offset/gain
  localparam logic [7:0] OTC_AO2_OFS     = 8'h0C; // Analog two offset/gain
  localparam logic [7:0] OTC_POL_OFS     = 8'h10; // Polarity digits, BCD
  localparam logic [7:0] OTC_DLY0_OFS    = 8'h14; // Delay of terminal 0, +4 each
  localparam logic [7:0] OTC_STAT_OFS    = 8'h28; // Terminal state readback
  localparam logic [7:0] OTC_SRC_OFS     = 8'h2C; // Source value write port
  localparam logic [7:0] OTC_RATE_OFS    = 8'h30; // Full-scale references write port
  localparam logic [7:0] OTC_OUTA_OFS    = 8'h34; // Analog results readback
  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int OTC_SEL_PULSE_LSB = 0;
  localparam int OTC_SEL_AO1_LSB   = 8;
  localparam int OTC_SEL_AO2_LSB   = 16;
  localparam int OTC_GAIN_LSB      = 16;
  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [4:0]  OTC_SEL_PULSE_RST = 5'h00; // Running frequency
  localparam logic [4:0]  OTC_SEL_AO1_RST   = 5'h00; // Running frequency
  localparam logic [4:0]  OTC_SEL_AO2_RST   = 5'h01; // Set frequency
  localparam logic [13:0] OTC_PMAX_RST      = 14'h1388; // 50.00 kHz
  localparam logic [13:0] OTC_PMIN          = 14'h0001; // 0.01 kHz
  localparam logic [13:0] OTC_PMAX_TOP      = 14'h2710; // 100.00 kHz
  localparam logic signed [15:0] OTC_OFS_RST  = 16'sh0000; // 0.0 %
  localparam logic signed [15:0] OTC_OFS_LIM  = 16'sh03E8; // 100.0 %
  localparam logic signed [15:0] OTC_GAIN_RST = 16'sh0064; // 1.00
  localparam logic signed [15:0] OTC_GAIN_LIM = 16'sh03E8; // 10.00
  localparam logic [19:0] OTC_POL_RST       = 20'h0_0000;
  localparam logic [15:0] OTC_DLY_RST       = 16'h0000; // 0.0 s
  localparam logic [15:0] OTC_DLY_TOP       = 16'h8CA0; // 3600.0 s in 0.1 s
  localparam logic [15:0] OTC_SPAN_FULL     = 16'h03E8; // 100.0 % in 0.1 %
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int OTC_CLK_HZ       = 100_000_000;
  localparam int OTC_TICK_MS      = 100; // Delay unit 0.1 s
  localparam int OTC_TICK_CYCLES  = OTC_CLK_HZ / 1000 * OTC_TICK_MS;
  localparam int OTC_NUM_TERM     = 5;
  // Source codes with a scaled reference
  localparam logic [4:0] OTC_SRC_SPD = 5'h0D;
endpackage : otc_pkg
`default_nettype wire

// ==== hdl/otc_delay.sv ====
// One switched terminal: hold-off delay, then polarity
`default_nettype none
module otc_delay
  import otc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,       // One pulse per 0.1 s
  input  wire logic [15:0] delay_set,  // Delay in 0.1 s
  input  wire logic        neg_logic,  // Polarity digit
  input  wire logic        status,     // Synchronised function state
  output logic             connected   // High: terminal tied to return
);
  logic        held_reg;  // Delayed function state
  logic [15:0] cnt_reg;   // Elapsed ticks since status change

  // Delay counter, restarts whenever the status differs again
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      held_reg <= 1'b0;
      cnt_reg  <= 16'h0000;
    end
    else if (status == held_reg)
      cnt_reg <= 16'h0000;
    else if (cnt_reg >= delay_set)
    begin
      held_reg <= status;
      cnt_reg  <= 16'h0000;
    end
    else if (tick)
      cnt_reg <= cnt_reg + 16'h0001;
  end

  // Polarity after delay so the delay governs the visible edge
  always_ff @(posedge clk)
  begin
    if (rst)
      connected <= 1'b0;
    else
      connected <= held_reg ^ neg_logic;
  end
endmodule : otc_delay
`default_nettype wire

// ==== hdl/otc_top.sv ====
// Output terminal conditioning: source select, scaling, delay, polarity
// Summary of operation
// - Function codes select pulse and analog sources
// - Pulse frequency kept between minimum and maximum
// - Maximum pulse frequency 0.01 to 100 kHz
// - Frequency sources scale to maximum frequency
// - Current, torque, power scale to twice rated
// - Voltage scales to 1.2 times rated
// - Speed scales to speed at maximum frequency
// - Analog output is gain times standard plus offset
// - Offset 100 percent equals full output
// - Offset and gain ranges and defaults
// - Per-terminal delay 0 to 3600 s
// - Five polarity digits, one per terminal
// - Digit 0: connected while active
// - Digit 1: disconnected while active
//
// Implementation choices: the register addresses and the Wishbone slave port.
`default_nettype none
module otc_top
  import otc_pkg::*;
#(
  parameter int TICK_CYCLES = OTC_TICK_CYCLES  // Cycles per 0.1 s delay unit
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [4:0]  term_status,          // Raw terminal functions, async
  output logic [4:0]       term_connected,       // 1: tied to common_return
  output logic [13:0]      pulse_output_terminal, // Frequency, 0.01 kHz units
  output logic [15:0]      analog_output_one,    // Signed, 0.1 % of full scale
  output logic [15:0]      analog_output_two     // Signed, 0.1 % of full scale
);
  // ==========================================================
  // Register file
  // ==========================================================
  logic [4:0]         sel_reg [3];        // Pulse, analog one, analog two
  logic [13:0]        pmax_reg;           // max_pulse_frequency_setting
  logic signed [15:0] ofs_reg [2];        // Offset coefficients, 0.1 %
  logic signed [15:0] gain_reg [2];       // Gains, 0.01
  logic [19:0]        pol_reg;            // output_polarity_setting, BCD
  logic [15:0]        dly_reg [OTC_NUM_TERM]; // Delays, 0.1 s
  logic [15:0]        src_reg [16];       // Live source values, by code
  logic [15:0]        ref_reg [16];       // Full-scale reference, by code
  logic [3:0]         src_idx_reg;        // Index register for source ports
  logic               ack_reg;

  wire logic req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire logic wr  = req && wb_we_i;

  // Clamp helpers for signed settings
  function automatic logic signed [15:0] otc_clamp(input logic signed [15:0] v,
                                                   input logic signed [15:0] lim);
    if (v > lim)
      otc_clamp = lim;
    else if (v < -lim)
      otc_clamp = -lim;
    else
      otc_clamp = v;
  endfunction : otc_clamp

  // Byte-lane merge used by the select, maximum frequency, analog and polarity writes
  function automatic logic [31:0] otc_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  sel);
    for (int b = 0; b < 4; b++)
      otc_merge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
  endfunction : otc_merge

  // Current words as seen by software
  logic [31:0] sel_word;
  logic [31:0] ao_word [2];
  assign sel_word = {11'h000, sel_reg[2], 3'h0, sel_reg[1], 3'h0, sel_reg[0]};
  assign ao_word[0] = {gain_reg[0], ofs_reg[0]};
  assign ao_word[1] = {gain_reg[1], ofs_reg[1]};

  logic [31:0] wdat_sel;
  logic [31:0] wdat_pmax;
  logic [31:0] wdat_ao [2];
  assign wdat_sel  = otc_merge(sel_word, wb_dat_i, wb_sel_i);
  assign wdat_pmax = otc_merge({18'h00000, pmax_reg}, wb_dat_i, wb_sel_i);
  assign wdat_ao[0] = otc_merge(ao_word[0], wb_dat_i, wb_sel_i);
  assign wdat_ao[1] = otc_merge(ao_word[1], wb_dat_i, wb_sel_i);

  // Source selects, max pulse frequency, polarity
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_reg[0] <= OTC_SEL_PULSE_RST;
      sel_reg[1] <= OTC_SEL_AO1_RST;
      sel_reg[2] <= OTC_SEL_AO2_RST;
      pmax_reg   <= OTC_PMAX_RST;
      pol_reg    <= OTC_POL_RST;
    end
    else if (wr)
    begin
      if (wb_adr_i == OTC_SEL_OFS)
      begin
        sel_reg[0] <= wdat_sel[OTC_SEL_PULSE_LSB +: 5];
        sel_reg[1] <= wdat_sel[OTC_SEL_AO1_LSB +: 5];
        sel_reg[2] <= wdat_sel[OTC_SEL_AO2_LSB +: 5];
      end
      if (wb_adr_i == OTC_PMAX_OFS)
      begin
        // Whole word compared so high bits cannot wrap back into range
        if (wdat_pmax < 32'(OTC_PMIN))
          pmax_reg <= OTC_PMIN;
        else if (wdat_pmax > 32'(OTC_PMAX_TOP))
          pmax_reg <= OTC_PMAX_TOP;
        else
          pmax_reg <= wdat_pmax[13:0];
      end
      if (wb_adr_i == OTC_POL_OFS)
        pol_reg <= 20'(otc_merge({12'h000, pol_reg}, wb_dat_i, wb_sel_i) & 32'h0001_1111);
    end
  end

  // Analog offset and gain pairs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 2; i++)
      begin
        ofs_reg[i]  <= OTC_OFS_RST;
        gain_reg[i] <= OTC_GAIN_RST;
      end
    end
    else if (wr)
    begin
      for (int i = 0; i < 2; i++)
        if (wb_adr_i == (i == 0 ? OTC_AO1_OFS : OTC_AO2_OFS))
        begin
          ofs_reg[i]  <= otc_clamp(wdat_ao[i][15:0], OTC_OFS_LIM);
          gain_reg[i] <= otc_clamp(wdat_ao[i][31:16], OTC_GAIN_LIM);
        end
    end
  end

  // Delay settings, one word per terminal, clamped to 3600.0 s
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < OTC_NUM_TERM; i++)
        dly_reg[i] <= OTC_DLY_RST;
    end
    else if (wr)
    begin
      for (int i = 0; i < OTC_NUM_TERM; i++)
        if (wb_adr_i == OTC_DLY0_OFS + 8'(4 * i))
          dly_reg[i] <= (wb_dat_i[15:0] > OTC_DLY_TOP) ? OTC_DLY_TOP
                                                      : wb_dat_i[15:0];
    end
  end

  // Source values and full-scale references from the drive core.
  // Word holds index in bits 19:16 and value in 15:0.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      src_idx_reg <= 4'h0;
      for (int i = 0; i < 16; i++)
      begin
        src_reg[i] <= 16'h0000;
        ref_reg[i] <= OTC_SPAN_FULL;
      end
    end
    else if (wr && wb_adr_i == OTC_SRC_OFS)
    begin
      src_idx_reg           <= wb_dat_i[19:16];
      src_reg[wb_dat_i[19:16]] <= wb_dat_i[15:0];
    end
    else if (wr && wb_adr_i == OTC_RATE_OFS)
    begin
      // Reference 0 means "not set"; keep it non-zero to avoid a divide by zero
      src_idx_reg <= wb_dat_i[19:16];
      ref_reg[wb_dat_i[19:16]] <= (wb_dat_i[15:0] == 16'h0000) ? 16'h0001
                                                              : wb_dat_i[15:0];
    end
  end

  // ==========================================================
  // Scaling to 0..100.0 %
  // ==========================================================
  // Full scale by code: maximum frequency for 0, 1 and 13, twice rated for
  // 2..4, 1.2 times rated for 5; the reference port holds the raw rating.
  function automatic logic [15:0] otc_pct(input logic [4:0] code);
    logic [31:0] fs;
    logic [31:0] num;
    logic [31:0] q;
    fs  = {16'h0000, ref_reg[code[3:0]]};
    num = 32'(src_reg[code[3:0]]) * 32'(OTC_SPAN_FULL);
    if (code >= 5'h02 && code <= 5'h04)
      fs = fs * 32'd2;
    else if (code == 5'h05)
      fs = (fs * 32'd12) / 32'd10;
    else if (code == OTC_SRC_SPD)
      fs = fs;
    else
      fs = fs;
    if (code > 5'h0F || fs == 32'h0)
      q = 32'h0;
    else
      q = num / fs;
    otc_pct = (q > 32'(OTC_SPAN_FULL)) ? OTC_SPAN_FULL : q[15:0];
  endfunction : otc_pct

  // Y = kX + b, X in 0.1 % units, k in 0.01, b in 0.1 % of 10 V / 20 mA
  function automatic logic [15:0] otc_ao(input logic [15:0] x,
                                         input logic signed [15:0] k,
                                         input logic signed [15:0] b);
    logic signed [31:0] y;
    y = (32'(signed'({1'b0, x[14:0]})) * 32'(k)) / 32'sd100 + 32'(b);
    if (y > 32'sd2000)
      y = 32'sd2000;
    else if (y < -32'sd2000)
      y = -32'sd2000;
    otc_ao = y[15:0];
  endfunction : otc_ao

  logic [15:0] pct_pulse;
  logic [31:0] pfreq;
  assign pct_pulse = otc_pct(sel_reg[0]);
  // Minimum plus scaled share of the span to the configured maximum
  assign pfreq = 32'(OTC_PMIN) +
                 (32'(pmax_reg - OTC_PMIN) * 32'(pct_pulse)) / 32'(OTC_SPAN_FULL);

  // Output results registered
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pulse_output_terminal <= OTC_PMIN;
      analog_output_one     <= 16'h0000;
      analog_output_two     <= 16'h0000;
    end
    else
    begin
      pulse_output_terminal <= (pfreq[13:0] > pmax_reg) ? pmax_reg : pfreq[13:0];
      analog_output_one     <= otc_ao(otc_pct(sel_reg[1]), gain_reg[0], ofs_reg[0]);
      analog_output_two     <= otc_ao(otc_pct(sel_reg[2]), gain_reg[1], ofs_reg[1]);
    end
  end

  // ==========================================================
  // Switched terminals
  // ==========================================================
  logic [4:0] sync1_reg;  // First stage, read only by stage two
  logic [4:0] sync2_reg;
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;
  logic [4:0]  conn_w;

  // Terminal status arrives from outside this clock
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
    end
    else
    begin
      sync1_reg <= term_status;
      sync2_reg <= sync1_reg;
    end
  end

  // Shared 0.1 s tick for all delay counters
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end
    else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1))
    begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  // Terminal order: 0 relay-mode two, 1 relay one, 2 relay two,
  // 3 switched one, 4 digital two; digit i of polarity steers terminal i
  genvar t;
  generate
    for (t = 0; t < OTC_NUM_TERM; t++)
    begin : g_term
      otc_delay u_delay
      (
        .clk       (clk),
        .rst       (rst),
        .tick      (tick_reg),
        .delay_set (dly_reg[t]),
        .neg_logic (pol_reg[4*t]),
        .status    (sync2_reg[t]),
        .connected (conn_w[t])
      );
    end
  endgenerate

  // Outputs straight from flip-flops
  always_ff @(posedge clk)
  begin
    if (rst)
      term_connected <= 5'h00;
    else
      term_connected <= conn_w;
  end

  // ==========================================================
  // Wishbone slave: one-cycle registered ack, reads zero if unmapped
  // ==========================================================
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_reg  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_reg  <= req;
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          OTC_SEL_OFS:  wb_dat_o <= sel_word;
          OTC_PMAX_OFS: wb_dat_o <= {18'h00000, pmax_reg};
          OTC_AO1_OFS:  wb_dat_o <= ao_word[0];
          OTC_AO2_OFS:  wb_dat_o <= ao_word[1];
          OTC_POL_OFS:  wb_dat_o <= {12'h000, pol_reg};
          OTC_STAT_OFS: wb_dat_o <= {22'h000000, term_connected, sync2_reg};
          OTC_SRC_OFS:  wb_dat_o <= {12'h000, src_idx_reg, src_reg[src_idx_reg]};
          OTC_RATE_OFS: wb_dat_o <= {12'h000, src_idx_reg, ref_reg[src_idx_reg]};
          OTC_OUTA_OFS: wb_dat_o <= {analog_output_two, analog_output_one};
          default:
          begin
            for (int i = 0; i < OTC_NUM_TERM; i++)
              if (wb_adr_i == OTC_DLY0_OFS + 8'(4 * i))
                wb_dat_o <= {16'h0000, dly_reg[i]};
          end
        endcase
      end
    end
  end
endmodule : otc_top
`default_nettype wire

// ==== verification/otc_props.sv ====
// Port-level checker for the output terminal conditioning block
`default_nettype none
module otc_props
  import otc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [4:0]  term_connected,
  input wire logic [13:0] pulse_output_terminal,
  input wire logic [15:0] analog_output_one,
  input wire logic [15:0] analog_output_two
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================================
  // Helper: writes taken at the last three edges
  // ======================================================
  // Outputs may legally move while any bit is set
  logic [2:0] wr_hist_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
      wr_hist_reg <= 3'h0;
    else
      wr_hist_reg <= {wr_hist_reg[1:0], wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ======================================================
  // Bus handshake
  // ======================================================
  chk_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged next cycle");
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");
  chk_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data driven outside ack");
  // ======================================================
  // Outputs
  // ======================================================
  chk_reset_state: assert property ($past(rst) |-> term_connected == 5'h00
    && pulse_output_terminal == OTC_PMIN && analog_output_one == 16'h0000)
    else $error("outputs not at reset state");
  chk_pulse_range: assert property (pulse_output_terminal >= OTC_PMIN
    && pulse_output_terminal <= OTC_PMAX_TOP)
    else $error("pulse frequency out of range");
  chk_analog_clamp: assert property ($signed(analog_output_one) >= -16'sh07D0
    && $signed(analog_output_one) <= 16'sh07D0)
    else $error("analog one beyond clamp");
  chk_pulse_holds: assert property (wr_hist_reg == 3'h0 |-> $stable(pulse_output_terminal))
    else $error("pulse moved without a setting change");
  chk_analog_holds: assert property (wr_hist_reg == 3'h0 |->
    $stable(analog_output_one) && $stable(analog_output_two))
    else $error("analog moved without a setting change");
  // Main scenarios reached
  cov_write: cover property (wb_ack_o && wb_we_i);
  cov_pulse_top: cover property (pulse_output_terminal == OTC_PMAX_TOP);
  cov_connected: cover property (term_connected != 5'h00);
endmodule : otc_props
`default_nettype wire

// ==== verification/otc_load.sv ====
// Load model: lamps wired between each terminal and the common return
`default_nettype none
module otc_load
(
  input  wire logic       clk,
  input  wire logic [4:0] contact, // High: terminal tied to return
  output var  logic [4:0] lamp     // Lit while its contact conducts
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================================
  // Contacts
  // ======================================================
  // One clock of lag, like a coil that needs time to pull in
  always_ff @(posedge clk)
  begin
    lamp <= contact;
  end
endmodule : otc_load
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the output terminal conditioning block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import otc_pkg::*;
  // ======================================================
  // Signals
  // ======================================================
  logic        clk     = 1'b0;          // 100 MHz
  logic        rst     = 1'b1;          // Held ten cycles
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [7:0]  wb_adr  = 8'h00;
  logic [3:0]  wb_sel  = 4'hF;          // Full words except in the byte-lane step
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [4:0]  status  = 5'h00;         // Drive function states
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [4:0]  conn;
  logic [4:0]  lamp;
  logic [13:0] pulse;
  logic [15:0] ao1;
  logic [15:0] ao2;
  logic [31:0] exp_q[$];                // Expected read data, oldest first
  logic [31:0] msk_q[$];                // Bits that matter per read
  logic [31:0] mon_msk;
  int          mismatches = 0;
  int          compares   = 0;
  int          seed       = 23763;
  int          i;
  logic [31:0] pm;
  logic [31:0] v;
  logic [4:0]  st;
  // Source code, value written, percent expected at unity gain
  logic [4:0]  code_tab [8] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h0D, 5'h08, 5'h11};
  logic [15:0] val_tab [8] = '{16'h0384, 16'h03E8, 16'h03E8, 16'h03E8, 16'h0258,
                               16'h00FA, 16'h012C, 16'h01F4};
  logic [15:0] pct_tab [8] = '{16'h0384, 16'h01F4, 16'h01F4, 16'h01F4, 16'h01F4,
                               16'h00FA, 16'h012C, 16'h0000};
  always #5 clk = ~clk;
  // ======================================================
  // Design and load
  // ======================================================
  // Short delay unit keeps the hold-off runs brief
  otc_top #(.TICK_CYCLES(4)) i_dut
  (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .term_status(status), .term_connected(conn),
    .pulse_output_terminal(pulse), .analog_output_one(ao1), .analog_output_two(ao2)
  );
  otc_load i_load (.clk(clk), .contact(conn), .lamp(lamp));
  // ======================================================
  // Reporting
  // ======================================================
  task automatic print_verdict;
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t output %h expected %h", $time, got, exp);
    end
  endtask : chk_pin
  // ======================================================
  // Bus master: holds the request until ack is sampled
  // ======================================================
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= dat;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 40);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    // A slave that never answers ends the run
    if (n >= 40)
    begin
      mismatches++;
      $display("CHECK FAILED %0t bus timeout", $time);
      print_verdict();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    xfer(1'b1, adr, dat);
  endtask : wr
  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
    exp_q.push_back(exp);
    msk_q.push_back(msk);
    xfer(1'b0, adr, 32'h0000_0000);
  endtask : rd
  // Read monitor: each acknowledged read settles the oldest note
  always @(posedge clk)
  begin
    if (wb_ack === 1'b1 && wb_we === 1'b0)
    begin
      mon_msk = msk_q.pop_front();
      chk_word(wb_rdat & mon_msk, exp_q.pop_front() & mon_msk);
    end
  end
  // ======================================================
  // Scenarios
  // ======================================================
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Settings come up at their defaults
    rd(OTC_SEL_OFS, 32'h0001_0000, 32'h001F_1F1F);
    rd(OTC_PMAX_OFS, 32'(OTC_PMAX_RST), 32'h0000_3FFF);
    rd(OTC_AO1_OFS, 32'h0064_0000, 32'hFFFF_FFFF);
    rd(OTC_AO2_OFS, 32'h0064_0000, 32'hFFFF_FFFF);
    rd(OTC_POL_OFS, 32'h0000_0000, 32'h0001_1111);
    for (i = 0; i < OTC_NUM_TERM; i++)
      rd(OTC_DLY0_OFS + 8'(4 * i), 32'h0000_0000, 32'h0000_FFFF);
    rd(8'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    // Pulse frequency over the span, with both clamp ends
    for (i = 0; i < 6; i++)
    begin
      pm = (i == 0) ? 32'h0 : (i == 1) ? 32'(OTC_PMAX_TOP) * 2
         : $unsigned($random(seed)) % 32'(OTC_PMAX_TOP) + 1;
      v  = (i == 1) ? 32'(OTC_SPAN_FULL) : $unsigned($random(seed)) % 1001;
      wr(OTC_PMAX_OFS, pm);
      wr(OTC_SRC_OFS, v);
      repeat (2) @(posedge clk);
      pm = (pm < OTC_PMIN) ? 32'(OTC_PMIN) : (pm > OTC_PMAX_TOP) ? 32'(OTC_PMAX_TOP) : pm;
      chk_pin(16'(pulse), 16'(OTC_PMIN + (pm - 1) * v / OTC_SPAN_FULL));
    end
    // Source codes 00h, 08h and 0Dh scale to their own reference, 02h-04h to twice it, 05h to 1.2 times it, 11h gives zero
    for (i = 0; i < 8; i++)
    begin
      wr(OTC_SEL_OFS, {11'h000, 5'h01, 3'h0, code_tab[i], 8'h00});
      wr(OTC_SRC_OFS, {12'h000, code_tab[i][3:0], val_tab[i]});
      rd(OTC_OUTA_OFS, {16'h0000, pct_tab[i]}, 32'h0000_FFFF);
    end
    // Gain -0.50 and offset 80 %: 8 V at zero, 3 V at full scale
    wr(OTC_SEL_OFS, 32'h0001_0000);
    wr(OTC_AO1_OFS, 32'hFFCE_0320);
    wr(OTC_SRC_OFS, 32'h0000_0000);
    rd(OTC_OUTA_OFS, 32'h0000_0320, 32'h0000_FFFF);
    wr(OTC_SRC_OFS, 32'h0000_03E8);
    wr(OTC_SRC_OFS, 32'h0001_02BC);
    rd(OTC_OUTA_OFS, 32'h02BC_012C, 32'hFFFF_FFFF);
    // Out-of-range gain is limited, result clamped
    wr(OTC_AO1_OFS, 32'h07D0_FC18);
    rd(OTC_AO1_OFS, 32'h03E8_FC18, 32'hFFFF_FFFF);
    rd(OTC_OUTA_OFS, 32'h02BC_07D0, 32'hFFFF_FFFF);
    chk_pin(ao1, 16'h07D0);
    chk_pin(ao2, 16'h02BC);
    // Byte lanes: only the pulse select byte is written
    wb_sel <= 4'h1;
    wr(OTC_SEL_OFS, 32'hFFFF_FF0D);
    wb_sel <= 4'hF;
    rd(OTC_SEL_OFS, 32'h0001_000D, 32'h001F_1F1F);
    // Mixed polarity, no delay
    wr(OTC_POL_OFS, 32'h0001_0101);
    for (i = 0; i < 6; i++)
    begin
      st = 5'($random(seed));
      status <= st;
      repeat (8) @(posedge clk);
      chk_pin({11'h000, conn}, {11'h000, st ^ 5'h15});
      chk_pin({11'h000, lamp}, {11'h000, st ^ 5'h15});
      rd(OTC_STAT_OFS, {22'h0, st ^ 5'h15, st}, 32'h0000_03FF);
    end
    // Delay limit, then a held-off change on an inverted terminal
    wr(OTC_DLY0_OFS, 32'h0000_FFFF);
    rd(OTC_DLY0_OFS, {16'h0000, OTC_DLY_TOP}, 32'h0000_FFFF);
    wr(OTC_DLY0_OFS, 32'h0000_0005);
    status <= st ^ 5'h01;
    repeat (8) @(posedge clk);
    chk_pin({11'h000, conn}, {11'h000, st ^ 5'h15});
    repeat (40) @(posedge clk);
    chk_pin({11'h000, conn}, {11'h000, st ^ 5'h14});
    print_verdict();
  end
endmodule : testbench
bind otc_top otc_props i_props
(
  .clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .term_connected,
  .pulse_output_terminal, .analog_output_one, .analog_output_two
);
`default_nettype wire
